/* design/serial_port_params.svh */
// constant definitions for the serial port block
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
// ==========================================================================
// register offsets (byte addresses)
`define OFF_CTRL     6'h00
`define OFF_MODE     6'h04
`define OFF_STAT     6'h08
`define OFF_MASK     6'h0c
`define OFF_RXDATA   6'h10
`define OFF_ERRCNT   6'h14
`define OFF_LINE     6'h18
// ==========================================================================
// control register bits (write one to act)
`define CTRL_RX_RST  0
`define CTRL_RX_EN   1
`define CTRL_RX_DIS  2
`define CTRL_RTS_LO  3
`define CTRL_RTS_HI  4
// ==========================================================================
// mode register fields
`define MODE_W       6
`define MODE_RST     6'h00
`define MODE_HS      0
`define MODE_T1      1
`define MODE_SPI     2
`define MODE_LEN_LO  3
`define MODE_LEN_HI  5
// ==========================================================================
// status bits
`define ST_RXRDY     0
`define ST_OVERLEN   1
`define ST_OVERRUN   2
`define ST_W         3
`define ST_RST       3'h0
// ==========================================================================
// timing: least ratio of internal clock to serial clock
`define CLK_RATIO    9
`endif

/* design/serial_port_pkg.sv */
// types for the serial port block
package serial_port_pkg;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_SHIFT = 2'b01,
    RX_LOCKED = 2'b10
  } rx_state_e;
endpackage

/* design/serial_port.sv */
// serial port receive/handshake block with wishbone register access
// Behaviour
// - error count register always reads zero
// - T1 mode locks receiver after any transmit
// - hardware handshake holds rts at its current value when full
// - rts force high bit drives rts high
// - rts force low bit drives rts low unless the force high bit is set in the same write
// - spi slave overlength frame flags error, corrupts later
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_params.svh"
module serial_port
  import serial_port_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [5:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             IRQ,
  input  wire logic        SCK,
  input  wire logic        RXD,
  input  wire logic        SEL_N,
  input  wire logic        TX_DONE,
  input  wire logic        DMA_FULL,
  output logic             RTS
);
  // ========================================================================
  // state
  typedef struct packed {
    logic [1:0]        sck_s;
    logic [1:0]        rxd_s;
    logic [1:0]        sel_s;
    logic [1:0]        txd_s;
    logic [1:0]        dma_s;
    logic              sck_d;
    logic              txd_d;
    rx_state_e         st;
    logic [7:0]        shf;
    logic [3:0]        cnt;
    logic [7:0]        rxdata;
    logic              rx_en;
    logic              corrupt;
    logic              t1_tx_seen;
    logic [`MODE_W-1:0] mode;
    logic [`ST_W-1:0]  stat;
    logic [`ST_W-1:0]  mask;
    logic              rts;
    logic              ack;
    logic [31:0]       dat;
    logic              irq;
  } state_s;
  state_s q_r, q_nxt;

  logic             wr, rd, acc;
  logic             sck_rise, tx_rise;
  logic [3:0]       len;
  logic [`ST_W-1:0] ev;

  always_comb begin
    q_nxt = q_r;
    ev = '0;
    acc = CYC_I & STB_I & ~q_r.ack;
    wr = acc & WE_I & SEL_I[0];
    rd = acc & ~WE_I;
    len = {1'b0, q_r.mode[`MODE_LEN_HI:`MODE_LEN_LO]} + 4'h5;
    // ======================================================================
    // synchronisers: two flops before any use
    q_nxt.sck_s = {q_r.sck_s[0], SCK};
    q_nxt.rxd_s = {q_r.rxd_s[0], RXD};
    q_nxt.sel_s = {q_r.sel_s[0], SEL_N};
    q_nxt.txd_s = {q_r.txd_s[0], TX_DONE};
    q_nxt.dma_s = {q_r.dma_s[0], DMA_FULL};
    q_nxt.sck_d = q_r.sck_s[1];
    q_nxt.txd_d = q_r.txd_s[1];
    // edge found by sampling; needs sck well below clk rate
    sck_rise = q_r.sck_s[1] & ~q_r.sck_d;
    tx_rise = q_r.txd_s[1] & ~q_r.txd_d;
    // ======================================================================
    // receiver
    if (q_r.mode[`MODE_T1] && tx_rise) begin
      q_nxt.t1_tx_seen = 1'b1;
    end
    case (q_r.st)
      RX_IDLE: begin
        if (q_r.t1_tx_seen) begin
          q_nxt.st = RX_LOCKED;
        end else if (q_r.rx_en && sck_rise && (!q_r.mode[`MODE_SPI] || !q_r.sel_s[1])) begin
          q_nxt.shf = {q_r.shf[6:0], q_r.rxd_s[1]};
          q_nxt.cnt = 4'h1;
          q_nxt.st = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (q_r.mode[`MODE_SPI] && q_r.sel_s[1]) begin
          // frame ended by deselect
          if (q_r.cnt > len) begin
            ev[`ST_OVERLEN] = 1'b1;
            q_nxt.corrupt = 1'b1;
          end else if (q_r.cnt == len) begin
            ev[`ST_RXRDY] = 1'b1;
            q_nxt.rxdata = q_r.corrupt ? ~q_r.shf : q_r.shf;
          end
          q_nxt.st = RX_IDLE;
        end else if (sck_rise) begin
          q_nxt.shf = {q_r.shf[6:0], q_r.rxd_s[1]};
          q_nxt.cnt = (q_r.cnt == 4'hf) ? q_r.cnt : q_r.cnt + 4'h1;
        end else if (!q_r.mode[`MODE_SPI] && q_r.cnt == len) begin
          ev[`ST_RXRDY] = 1'b1;
          q_nxt.rxdata = q_r.shf;
          q_nxt.st = RX_IDLE;
        end
      end
      RX_LOCKED: begin
        q_nxt.st = RX_LOCKED;
      end
      default: begin
        q_nxt.st = RX_IDLE;
      end
    endcase
    if (ev[`ST_RXRDY] && q_r.stat[`ST_RXRDY]) begin
      ev[`ST_OVERRUN] = 1'b1;
    end
    // ======================================================================
    // request to send: hardware handshake never raises it
    if (q_r.mode[`MODE_HS] && q_r.dma_s[1]) begin
      q_nxt.rts = q_r.rts;
    end
    // ======================================================================
    // bus slave, single-cycle ack
    q_nxt.ack = acc;
    q_nxt.dat = '0;
    if (wr) begin
      if (ADR_I == `OFF_CTRL) begin
        if (DAT_I[`CTRL_RX_RST]) begin
          // clears shift state and status; mode untouched; corrupt stays
          q_nxt.st = RX_IDLE;
          q_nxt.cnt = '0;
          q_nxt.shf = '0;
          q_nxt.t1_tx_seen = 1'b0;
          q_nxt.stat = `ST_RST;
          ev = '0;
        end
        if (DAT_I[`CTRL_RX_EN]) begin
          q_nxt.rx_en = 1'b1;
        end
        if (DAT_I[`CTRL_RX_DIS]) begin
          q_nxt.rx_en = 1'b0;
        end
        if (DAT_I[`CTRL_RTS_LO]) begin
          q_nxt.rts = 1'b0;
        end
        if (DAT_I[`CTRL_RTS_HI]) begin
          q_nxt.rts = 1'b1;
        end
      end else if (ADR_I == `OFF_MODE) begin
        q_nxt.mode = DAT_I[`MODE_W-1:0];
      end else if (ADR_I == `OFF_STAT) begin
        q_nxt.stat = q_r.stat & ~DAT_I[`ST_W-1:0];
      end else if (ADR_I == `OFF_MASK) begin
        q_nxt.mask = DAT_I[`ST_W-1:0];
      end
    end
    if (rd) begin
      if (ADR_I == `OFF_CTRL) begin
        q_nxt.dat = '0;
      end else if (ADR_I == `OFF_MODE) begin
        q_nxt.dat = {26'h0, q_r.mode};
      end else if (ADR_I == `OFF_STAT) begin
        q_nxt.dat = {29'h0, q_r.stat};
      end else if (ADR_I == `OFF_MASK) begin
        q_nxt.dat = {29'h0, q_r.mask};
      end else if (ADR_I == `OFF_RXDATA) begin
        q_nxt.dat = {24'h0, q_r.rxdata};
        q_nxt.stat[`ST_RXRDY] = 1'b0;
      end else if (ADR_I == `OFF_ERRCNT) begin
        q_nxt.dat = 32'h0;
      end else if (ADR_I == `OFF_LINE) begin
        q_nxt.dat = {28'h0, q_r.t1_tx_seen, q_r.corrupt, q_r.rx_en, q_r.rts};
      end
    end
    // set wins over clear
    q_nxt.stat = q_nxt.stat | ev;
    q_nxt.irq = |(q_nxt.stat & q_r.mask);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign DAT_O = q_r.dat;
  assign ACK_O = q_r.ack;
  assign IRQ = q_r.irq;
  assign RTS = q_r.rts;

  // ========================================================================
  // checks
  property p_errcnt_zero;
    @(posedge CLK) disable iff (RST)
      (rd && ADR_I == `OFF_ERRCNT) |=> (ACK_O && DAT_O == 32'h0);
  endproperty
  a_errcnt_zero: assert property (p_errcnt_zero) else $error("error count not zero");

  property p_t1_lock;
    @(posedge CLK) disable iff (RST)
      (q_r.st == RX_LOCKED && !(wr && ADR_I == `OFF_CTRL)) |=> q_r.st == RX_LOCKED;
  endproperty
  a_t1_lock: assert property (p_t1_lock) else $error("receiver left lockout");

  property p_hs_no_rise;
    @(posedge CLK) disable iff (RST)
      (q_r.mode[`MODE_HS] && !RTS && !(wr && ADR_I == `OFF_CTRL)) |=> !RTS;
  endproperty
  a_hs_no_rise: assert property (p_hs_no_rise) else $error("rts rose by itself");

  property p_rts_hi;
    @(posedge CLK) disable iff (RST)
      (wr && ADR_I == `OFF_CTRL && DAT_I[`CTRL_RTS_HI]) |=> RTS;
  endproperty
  a_rts_hi: assert property (p_rts_hi) else $error("rts not forced high");

  property p_rts_lo;
    @(posedge CLK) disable iff (RST)
      (wr && ADR_I == `OFF_CTRL && DAT_I[`CTRL_RTS_LO] && !DAT_I[`CTRL_RTS_HI]) |=> !RTS;
  endproperty
  a_rts_lo: assert property (p_rts_lo) else $error("rts not forced low");

  property p_overlen;
    @(posedge CLK) disable iff (RST)
      (q_r.st == RX_SHIFT && q_r.mode[`MODE_SPI] && q_r.sel_s[1] && q_r.cnt > len
       && !(wr && ADR_I == `OFF_CTRL)) |=> (q_r.stat[`ST_OVERLEN] && q_r.corrupt);
  endproperty
  a_overlen: assert property (p_overlen) else $error("overlength not flagged");

  property p_mode_kept;
    @(posedge CLK) disable iff (RST)
      (wr && ADR_I == `OFF_CTRL && DAT_I[`CTRL_RX_RST]) |=> (q_r.mode == $past(q_r.mode)
       && q_r.st == RX_IDLE && q_r.stat == `ST_RST);
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("soft reset broke mode");

  property p_ack_once;
    @(posedge CLK) disable iff (RST)
      ACK_O |=> !ACK_O;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_ack_follows;
    @(posedge CLK) disable iff (RST)
      (CYC_I && STB_I && !ACK_O) |=> ACK_O;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

  property p_dat_idle;
    @(posedge CLK) disable iff (RST)
      !ACK_O |-> (DAT_O == 32'h0);
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

  // irq lags a mask write by one cycle, so only compare while the mask is steady
  property p_irq_level;
    @(posedge CLK) disable iff (RST)
      (q_r.mask == $past(q_r.mask)) |-> (IRQ == |(q_r.stat & q_r.mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq does not follow status");

  property p_rx_off;
    @(posedge CLK) disable iff (RST)
      (!q_r.rx_en && q_r.st == RX_IDLE) |=> (q_r.st != RX_SHIFT);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("disabled receiver started");

  property p_t1_arm;
    @(posedge CLK) disable iff (RST)
      (q_r.mode[`MODE_T1] && tx_rise && !(wr && ADR_I == `OFF_CTRL)) |=> q_r.t1_tx_seen;
  endproperty
  a_t1_arm: assert property (p_t1_arm) else $error("transmit did not arm lockout");

  property p_hs_full;
    @(posedge CLK) disable iff (RST)
      (q_r.mode[`MODE_HS] && q_r.dma_s[1] && !(wr && ADR_I == `OFF_CTRL)) |=> (RTS == $past(RTS));
  endproperty
  a_hs_full: assert property (p_hs_full) else $error("buffer full moved rts");

  property p_spi_ready;
    @(posedge CLK) disable iff (RST)
      (q_r.st == RX_SHIFT && q_r.mode[`MODE_SPI] && q_r.sel_s[1] && q_r.cnt == len
       && !(wr && ADR_I == `OFF_CTRL)) |=> q_r.stat[`ST_RXRDY];
  endproperty
  a_spi_ready: assert property (p_spi_ready) else $error("exact frame not received");

  // only a full reset clears corruption; soft reset must leave it
  property p_corrupt_sticky;
    @(posedge CLK) disable iff (RST)
      q_r.corrupt |=> q_r.corrupt;
  endproperty
  a_corrupt_sticky: assert property (p_corrupt_sticky) else $error("corruption cleared");
endmodule
`default_nettype wire

/* tb/serial_peer.sv */
// serial peer model: spi master or card driving the receive side
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  output var logic sck,
  output var logic rxd,
  output var logic sel_n,
  output var logic tx_done,
  output var logic dma_full
);
  initial begin
    sck = 1'b0;
    rxd = 1'b1;
    sel_n = 1'b1;
    tx_done = 1'b0;
    dma_full = 1'b0;
  end
  // ==========================================================================
  // frame: msb first, sck still outside frames
  // 36 ns period, not 32: eight clocks per bit would break the ratio
  task automatic send(input int n, input logic [8:0] d);
    sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      rxd = d[i];
      #18 sck = 1'b1;
      #18 sck = 1'b0;
    end
    // released line shows the inverse, not a stale copy
    #18 rxd = ~rxd;
    sel_n = 1'b1;
    #80;
  endtask
  task automatic txd();
    tx_done = 1'b1;
    #40 tx_done = 1'b0;
    #40;
  endtask
  task automatic full(input logic v);
    dma_full = v;
  endtask
endmodule
`default_nettype wire

/* tb/serial_port_tb.sv */
// self-checking bench for the serial port block
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_params.svh"
module serial_port_tb;
  logic        CLK = 1'b0, RST = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic [5:0]  ADR_I = 6'h00;
  logic [3:0]  SEL_I = 4'hf;
  logic [31:0] DAT_I = 32'h0, DAT_O, q;
  logic        ACK_O, IRQ, SCK, RXD, SEL_N, TX_DONE, DMA_FULL, RTS;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  localparam logic [31:0] LEN8 = 32'h3 << `MODE_LEN_LO;
  localparam logic [31:0] SPI8 = (32'h1 << `MODE_SPI) | LEN8;
  localparam logic [31:0] T1M8 = (32'h1 << `MODE_T1) | LEN8;
  serial_port uut (.CLK(CLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ), .SCK(SCK), .RXD(RXD),
    .SEL_N(SEL_N), .TX_DONE(TX_DONE), .DMA_FULL(DMA_FULL), .RTS(RTS));
  serial_peer peer (.sck(SCK), .rxd(RXD), .sel_n(SEL_N), .tx_done(TX_DONE), .dma_full(DMA_FULL));
  always #2 CLK = ~CLK;
  // ==========================================================================
  // bus access and checking
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    // peer tasks return off the clock; start every request just after a rising edge
    @(posedge CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= d;
    do @(posedge CLK); while (ACK_O !== 1'b1);
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  // extra edge lets registered pins settle before they are looked at
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
    @(posedge CLK);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(`OFF_ERRCNT, 32'h0, "errcnt");
    rd(6'h3c, 32'h0, "unmapped");
    wr(`OFF_MODE, 32'h1 << `MODE_HS);
    peer.full(1'b1);
    repeat (8) @(posedge CLK);
    chk("rts on full", 32'h0, {31'h0, RTS});
    // software handshake in normal mode instead
    wr(`OFF_MODE, 32'h0);
    wr(`OFF_CTRL, 32'h1 << `CTRL_RTS_HI);
    chk("rts forced high", 32'h1, {31'h0, RTS});
    peer.full(1'b0);
    wr(`OFF_CTRL, 32'h1 << `CTRL_RTS_LO);
    chk("rts forced low", 32'h0, {31'h0, RTS});
    // t1: lockout after a transmit, recovery sequence
    wr(`OFF_MODE, T1M8);
    wr(`OFF_CTRL, 32'h1 << `CTRL_RX_EN);
    peer.txd();
    peer.send(8, 9'h05a);
    rd(`OFF_STAT, 32'h0, "t1 locked");
    wr(`OFF_CTRL, 32'h1 << `CTRL_RX_RST);
    wr(`OFF_MODE, T1M8);
    wr(`OFF_CTRL, 32'h1 << `CTRL_RX_EN);
    peer.send(8, 9'h05a);
    rd(`OFF_RXDATA, 32'h5a, "t1 data");
    // spi slave: exact frame, overlong frame, then corruption
    wr(`OFF_MODE, SPI8);
    peer.send(8, 9'h0a5);
    rd(`OFF_RXDATA, 32'ha5, "spi data");
    wr(`OFF_MASK, 32'h2);
    peer.send(9, 9'h1a5);
    chk("irq", 32'h1, {31'h0, IRQ});
    wb(1'b0, `OFF_STAT, 32'h0);
    chk("overlen", 32'h2, q & 32'h2);
    wr(`OFF_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    wr(`OFF_MASK, 32'h2);
    wr(`OFF_STAT, 32'h2);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
    wr(`OFF_STAT, 32'h0);
    peer.send(9, 9'h1a5);
    wr(`OFF_CTRL, 32'h1 << `CTRL_RX_DIS);
    wr(`OFF_CTRL, 32'h1 << `CTRL_RX_RST);
    rd(`OFF_MODE, SPI8, "mode kept");
    rd(`OFF_STAT, 32'h0, "status cleared");
    chk("irq after soft reset", 32'h0, {31'h0, IRQ});
    wr(`OFF_CTRL, 32'h1 << `CTRL_RX_EN);
    peer.send(8, 9'h03c);
    wb(1'b0, `OFF_RXDATA, 32'h0);
    chk("corrupt data", 32'hc3, q & 32'hff);
    rd(`OFF_LINE, 32'h6, "line state");
    rd(`OFF_ERRCNT, 32'h0, "errcnt after errors");
    tally_and_finish();
  end
endmodule
`default_nettype wire
